// *** chdiv_top.sv ***
// Notes on behaviour
// - Low phase lasts low field plus one.
// - High phase lasts high field plus one.
// - Bypass bit passes input straight through.
// - Nosync bit makes divider ignore sync.
// - Force bit sets static level with nosync.
// - Start-high bit picks the first level.
// - Phase offset delays start by nibble prescaler ticks.
// - Direct bit routes VCO or external clock.
// - Routing bit 0 disables duty correction.
// - Prescaler divides 2 to 6, else static.
// - Bit 4 powers down clock input section.
// - Bit 3 powers down VCO interface.
// - Bit 2 powers down VCO and input.
// - Bit 1 selects VCO or external clock.
// - Bit 0 bypasses the prescaler.
// - Settings act only after update bit.
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
module chdiv_top
  import chdiv_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [8:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Source clock events, one pulse per source clock cycle
  input wire logic vco_tick_in,
  input wire logic ext_clk_tick_in,
  // Chip-level sync pin, low holds the divider
  input wire logic sync_n_in,
  // Output pair and power controls
  output logic pair_c_first_output_out,
  output logic pair_c_second_output_out,
  output logic duty_correction_enable_out,
  output logic pd_input_section_out,
  output logic pd_vco_iface_out,
  output logic pd_sources_out,
  output logic divider_powered_down_out
);

  chdiv_state_s s_q;
  chdiv_state_s s_d;
  chdiv_bus_s bus;
  chdiv_regs_s a;
  logic src_tick;
  logic src_alive;
  logic [3:0] low_len;
  logic [3:0] high_len;
  logic [1:0] sel_field;
  logic direct_on;
  logic direct_tick;
  logic sync_obeyed;
  logic forced;
  logic [7:0] rd_val;

  always_comb
  begin
    bus.addr = reg_addr_in;
    bus.wdata = reg_wdata_in;
    bus.wr = reg_wr_in;
    bus.rd = reg_rd_in;
  end

  assign a = s_q.act;
  assign low_len = a.phase[CHDIV_LOW_LSB +: 4];
  assign high_len = a.phase[CHDIV_HIGH_LSB +: 4];
  assign sel_field = {a.input_sel[CHDIV_SEL_VCO_BIT], a.input_sel[CHDIV_PRE_BYP_BIT]};

  // ==========================================================
  // Source selection and power-down gating
  always_comb
  begin
    src_alive = !a.input_sel[CHDIV_PD_INPUT_BIT] && !a.input_sel[CHDIV_PD_SRC_BIT];
    if (a.input_sel[CHDIV_SEL_VCO_BIT])
    begin
      src_tick = vco_tick_in && src_alive && !a.input_sel[CHDIV_PD_IFACE_BIT];
    end
    else
    begin
      src_tick = ext_clk_tick_in && src_alive;
    end
    direct_on = 1'b0;
    direct_tick = 1'b0;
    if (a.route[CHDIV_DIRECT_BIT])
    begin
      // Code 01b leaves the divider path in place
      if (sel_field == CHDIV_SEL_DIRECT_VCO)
      begin
        direct_on = 1'b1;
        direct_tick = src_tick;
      end
      else if (sel_field == CHDIV_SEL_DIRECT_EXT)
      begin
        direct_on = 1'b1;
        direct_tick = src_tick;
      end
    end
    sync_obeyed = !a.ctrl[CHDIV_NOSYNC_BIT];
    forced = a.ctrl[CHDIV_NOSYNC_BIT] && a.ctrl[CHDIV_FORCE_BIT];
  end

  // ==========================================================
  // Read mux shows buffered settings, not active ones
  always_comb
  begin
    case (bus.addr)
      CHDIV_OFS_PHASE: rd_val = s_q.buf_r.phase;
      CHDIV_OFS_CTRL: rd_val = s_q.buf_r.ctrl;
      CHDIV_OFS_ROUTE: rd_val = s_q.buf_r.route;
      CHDIV_OFS_RATIO: rd_val = s_q.buf_r.ratio;
      CHDIV_OFS_INPUT: rd_val = s_q.buf_r.input_sel;
      CHDIV_OFS_STATUS: rd_val = {3'h0, s_q.sync_active, s_q.st, s_q.pre_tick, s_q.div_level};
      default: rd_val = 8'h00;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = bus.rd ? rd_val : s_q.rdata;
    // Buffer writes
    if (bus.wr)
    begin
      case (bus.addr)
        CHDIV_OFS_PHASE: s_d.buf_r.phase = bus.wdata;
        CHDIV_OFS_CTRL: s_d.buf_r.ctrl = bus.wdata;
        CHDIV_OFS_ROUTE: s_d.buf_r.route = {6'h00, bus.wdata[1:0]};
        CHDIV_OFS_RATIO: s_d.buf_r.ratio = {5'h00, bus.wdata[2:0]};
        CHDIV_OFS_INPUT: s_d.buf_r.input_sel = {3'h0, bus.wdata[4:0]};
        default: s_d.buf_r = s_q.buf_r;
      endcase
    end
    // Update bit self-clears; transfer on the following edge
    s_d.update_pend = bus.wr && (bus.addr == CHDIV_OFS_UPDATE) && bus.wdata[CHDIV_UPDATE_BIT];
    if (s_q.update_pend)
    begin
      s_d.act = s_q.buf_r;
    end

    // Three-stage sync input; second and third must agree
    s_d.sync_pipe = {s_q.sync_pipe[1:0], !sync_n_in};
    if (s_q.sync_pipe[2] == s_q.sync_pipe[1])
    begin
      s_d.sync_active = s_q.sync_pipe[2];
    end

    // Prescaler
    s_d.pre_tick = 1'b0;
    if (a.input_sel[CHDIV_PRE_BYP_BIT])
    begin
      s_d.pre_tick = src_tick;
      s_d.pre_cnt = 3'h0;
    end
    else if (a.ratio[2:0] > CHDIV_RATIO_MAX_CODE)
    begin
      s_d.pre_cnt = 3'h0;
    end
    else if (src_tick)
    begin
      if (s_q.pre_cnt >= a.ratio[2:0] + CHDIV_RATIO_BASE - 3'h1)
      begin
        s_d.pre_cnt = 3'h0;
        s_d.pre_tick = 1'b1;
      end
      else
      begin
        s_d.pre_cnt = s_q.pre_cnt + 3'h1;
      end
    end

    // Channel divider
    case (s_q.st)
      CHDIV_ST_HOLD:
      begin
        s_d.div_level = a.ctrl[CHDIV_START_BIT];
        s_d.cnt = a.ctrl[CHDIV_OFFSET_LSB +: 4];
        if (!(s_q.sync_active && sync_obeyed))
        begin
          s_d.st = CHDIV_ST_OFFSET;
        end
      end
      CHDIV_ST_OFFSET:
      begin
        if (s_q.cnt == 4'h0)
        begin
          s_d.st = CHDIV_ST_RUN;
          s_d.cnt = a.ctrl[CHDIV_START_BIT] ? high_len : low_len;
        end
        else if (s_q.pre_tick)
        begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      CHDIV_ST_RUN:
      begin
        if (s_q.pre_tick)
        begin
          if (s_q.cnt == 4'h0)
          begin
            // Each phase lasts field plus one prescaler ticks
            s_d.div_level = !s_q.div_level;
            s_d.cnt = s_q.div_level ? low_len : high_len;
          end
          else
          begin
            s_d.cnt = s_q.cnt - 4'h1;
          end
        end
      end
      default:
      begin
        s_d.st = CHDIV_ST_HOLD;
      end
    endcase
    if ((s_q.sync_active && sync_obeyed) || s_q.update_pend)
    begin
      // Settings change or sync restarts from the start level
      s_d.st = CHDIV_ST_HOLD;
    end

    // Output pair
    if (direct_on)
    begin
      if (direct_tick)
      begin
        s_d.out_first = !s_q.out_first;
      end
    end
    else if (forced)
    begin
      s_d.out_first = 1'b1;
    end
    else if (a.ctrl[CHDIV_BYPASS_BIT])
    begin
      if (s_q.pre_tick)
      begin
        s_d.out_first = !s_q.out_first;
      end
    end
    else
    begin
      s_d.out_first = s_d.div_level;
    end
    s_d.out_second = !s_d.out_first;

    s_d.pd = {!a.route[CHDIV_DCC_OFF_BIT], a.input_sel[CHDIV_PD_INPUT_BIT],
              a.input_sel[CHDIV_PD_IFACE_BIT], a.input_sel[CHDIV_PD_SRC_BIT],
              a.ctrl[CHDIV_BYPASS_BIT]};
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s_q <= '{buf_r: '{CHDIV_RST_PHASE, CHDIV_RST_CTRL, CHDIV_RST_ROUTE, CHDIV_RST_RATIO, CHDIV_RST_INPUT},
               act: '{CHDIV_RST_PHASE, CHDIV_RST_CTRL, CHDIV_RST_ROUTE, CHDIV_RST_RATIO, CHDIV_RST_INPUT},
               update_pend: 1'b0, sync_pipe: 3'h0, sync_active: 1'b0, st: CHDIV_ST_HOLD,
               cnt: 4'h0, pre_cnt: 3'h0, pre_tick: 1'b0, div_level: 1'b0,
               out_first: 1'b0, out_second: 1'b1, rdata: 8'h00, pd: 5'h10};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out = s_q.rdata;
  assign pair_c_first_output_out = s_q.out_first;
  assign pair_c_second_output_out = s_q.out_second;
  assign duty_correction_enable_out = s_q.pd[4];
  assign pd_input_section_out = s_q.pd[3];
  assign pd_vco_iface_out = s_q.pd[2];
  assign pd_sources_out = s_q.pd[1];
  assign divider_powered_down_out = s_q.pd[0];

endmodule

// *** chdiv_pkg.sv ***
package chdiv_pkg;

  // ==========================================================
  // Register map
  localparam logic [8:0] CHDIV_OFS_PHASE = 9'h196;
  localparam logic [8:0] CHDIV_OFS_CTRL = 9'h197;
  localparam logic [8:0] CHDIV_OFS_ROUTE = 9'h198;
  localparam logic [8:0] CHDIV_OFS_RATIO = 9'h1E0;
  localparam logic [8:0] CHDIV_OFS_INPUT = 9'h1E1;
  localparam logic [8:0] CHDIV_OFS_UPDATE = 9'h232;
  localparam logic [8:0] CHDIV_OFS_STATUS = 9'h1F0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CHDIV_RST_PHASE = 8'h00;
  localparam logic [7:0] CHDIV_RST_CTRL = 8'h00;
  localparam logic [7:0] CHDIV_RST_ROUTE = 8'h00;
  localparam logic [7:0] CHDIV_RST_RATIO = 8'h02;
  localparam logic [7:0] CHDIV_RST_INPUT = 8'h00;

  // ==========================================================
  // Field positions
  localparam int CHDIV_LOW_LSB = 4;
  localparam int CHDIV_HIGH_LSB = 0;
  localparam int CHDIV_BYPASS_BIT = 7;
  localparam int CHDIV_NOSYNC_BIT = 6;
  localparam int CHDIV_FORCE_BIT = 5;
  localparam int CHDIV_START_BIT = 4;
  localparam int CHDIV_OFFSET_LSB = 0;
  localparam int CHDIV_DIRECT_BIT = 1;
  localparam int CHDIV_DCC_OFF_BIT = 0;
  localparam int CHDIV_PD_INPUT_BIT = 4;
  localparam int CHDIV_PD_IFACE_BIT = 3;
  localparam int CHDIV_PD_SRC_BIT = 2;
  localparam int CHDIV_SEL_VCO_BIT = 1;
  localparam int CHDIV_PRE_BYP_BIT = 0;
  localparam int CHDIV_UPDATE_BIT = 0;

  // Input select field values for direct routing
  localparam logic [1:0] CHDIV_SEL_DIRECT_VCO = 2'b10;
  localparam logic [1:0] CHDIV_SEL_DIRECT_EXT = 2'b00;
  // Prescaler: code 0 divides by 2, codes above this are static
  localparam logic [2:0] CHDIV_RATIO_BASE = 3'h2;
  localparam logic [2:0] CHDIV_RATIO_MAX_CODE = 3'h4;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    CHDIV_ST_HOLD = 2'b00,
    CHDIV_ST_OFFSET = 2'b01,
    CHDIV_ST_RUN = 2'b11
  } chdiv_state_e;

  typedef struct packed {
    logic [7:0] phase;
    logic [7:0] ctrl;
    logic [7:0] route;
    logic [7:0] ratio;
    logic [7:0] input_sel;
  } chdiv_regs_s;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } chdiv_bus_s;

  typedef struct packed {
    chdiv_regs_s buf_r;
    chdiv_regs_s act;
    logic update_pend;
    logic [2:0] sync_pipe;
    logic sync_active;
    chdiv_state_e st;
    logic [3:0] cnt;
    logic [2:0] pre_cnt;
    logic pre_tick;
    logic div_level;
    logic out_first;
    logic out_second;
    logic [7:0] rdata;
    logic [4:0] pd;
  } chdiv_state_s;

endpackage

// *** chdiv_props.sv ***
`timescale 1ns/100ps
module chdiv_props
  import chdiv_pkg::*;
(
  // Clock, reset and register port
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [8:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Outputs
  input wire logic pair_c_first_output_out,
  input wire logic pair_c_second_output_out,
  input wire logic duty_correction_enable_out,
  input wire logic pd_input_section_out,
  input wire logic pd_vco_iface_out,
  input wire logic pd_sources_out,
  input wire logic divider_powered_down_out
);
  // ========================================
  // Helpers
  logic upd;
  logic [4:0] cfg_out;
  assign upd = reg_wr_in && reg_addr_in == CHDIV_OFS_UPDATE && reg_wdata_in[CHDIV_UPDATE_BIT];
  assign cfg_out = {duty_correction_enable_out, pd_input_section_out, pd_vco_iface_out, pd_sources_out,
                    divider_powered_down_out};
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  // ========================================
  // Properties
  a_pair_complement: assert property (
    pair_c_second_output_out == !pair_c_first_output_out) else $error("pair not complementary");
  // Buffered settings may only reach the pins three edges after an update
  a_update_gates_out: assert property (
    $changed(cfg_out) |-> $past(upd, 3)) else $error("output changed without update");
  a_unmapped_zero: assert property (
    reg_rd_in && reg_addr_in == 9'h100 |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_update_reads_zero: assert property (
    reg_rd_in && reg_addr_in == CHDIV_OFS_UPDATE |=> reg_rdata_out == 8'h00) else $error("update reads nonzero");
  a_ratio_mask: assert property (
    reg_rd_in && reg_addr_in == CHDIV_OFS_RATIO |=> reg_rdata_out[7:3] == 5'h00) else $error("ratio mask");
  a_input_mask: assert property (
    reg_rd_in && reg_addr_in == CHDIV_OFS_INPUT |=> reg_rdata_out[7:5] == 3'h0) else $error("input mask");
  a_rdata_holds: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out)) else $error("read data moved");
  // Write, one cycle without a phase write, then the read of the same register
  a_write_readback: assert property (
    reg_wr_in && reg_addr_in == CHDIV_OFS_PHASE ##1 !(reg_wr_in && reg_addr_in == CHDIV_OFS_PHASE)
    ##1 reg_rd_in && reg_addr_in == CHDIV_OFS_PHASE
    |=> reg_rdata_out == $past(reg_wdata_in, 3)) else $error("readback differs");
endmodule
bind chdiv_top chdiv_props chdiv_props_inst (.sys_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .pair_c_first_output_out, .pair_c_second_output_out, .duty_correction_enable_out,
  .pd_input_section_out, .pd_vco_iface_out, .pd_sources_out, .divider_powered_down_out);

// *** testbench.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("Error %0t %0h %0h", $time, a, b); end end
module testbench;
  import chdiv_pkg::*;
  logic sys_clk_in = 0;
  logic reset_in = 1;
  logic [8:0] reg_addr_in = 0;
  logic [7:0] reg_wdata_in = 0;
  logic [7:0] reg_rdata_out;
  logic reg_wr_in = 0;
  logic reg_rd_in = 0;
  logic vco_tick_in = 0;
  logic ext_clk_tick_in = 1;
  logic sync_n_in = 1;
  logic pair_c_first_output_out, pair_c_second_output_out, duty_correction_enable_out;
  logic pd_input_section_out, pd_vco_iface_out, pd_sources_out, divider_powered_down_out;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int h, l;
  logic obs;
  chdiv_top chdiv_top_inst (.sys_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .vco_tick_in, .ext_clk_tick_in, .sync_n_in, .pair_c_first_output_out,
    .pair_c_second_output_out, .duty_correction_enable_out, .pd_input_section_out, .pd_vco_iface_out,
    .pd_sources_out, .divider_powered_down_out);
  initial
  begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // ========================================
  // Tasks
  task give_verdict;
    $display("Compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict;
    end
  end
  // Output seen mid-cycle, away from the edge that launches it
  always @(negedge sys_clk_in)
  begin
    obs <= pair_c_first_output_out;
  end
  task step;
    @(posedge sys_clk_in);
  endtask
  // Tasks start and end on a rising edge; the idle cycle keeps each strobe single
  task wr(input logic [8:0] a, input logic [7:0] d);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  // Read data appear in the cycle after the strobe and hold until the next read, so look mid-cycle
  task rd(input logic [8:0] a, input logic [7:0] e);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge sys_clk_in);
    `CHK(reg_rdata_out, e)
    @(posedge sys_clk_in);
  endtask
  task upd;
    wr(9'h232, 8'h01);
    repeat (4) step;
  endtask
  // Waits past the restart, then times one high and one low phase
  task meas(input int eh, input int el);
    repeat (30) step;
    h = 0;
    while (obs !== 1'b0 && h < 60)
    begin
      step;
      h++;
    end
    while (obs !== 1'b1 && h < 99)
    begin
      step;
      h++;
    end
    h = 0;
    l = 0;
    while (obs === 1'b1 && h < 60)
    begin
      step;
      h++;
    end
    while (obs === 1'b0 && l < 60)
    begin
      step;
      l++;
    end
    `CHK(h, eh)
    `CHK(l, el)
  endtask
  // ========================================
  // Sequence
  initial
  begin
    repeat (12) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    step;
    rd(9'h196, CHDIV_RST_PHASE);
    rd(9'h197, CHDIV_RST_CTRL);
    rd(9'h198, CHDIV_RST_ROUTE);
    rd(9'h1E0, CHDIV_RST_RATIO);
    rd(9'h1E1, CHDIV_RST_INPUT);
    rd(9'h100, 8'h00);
    wr(9'h1E1, 8'hFC);
    wr(9'h197, 8'h80);
    wr(9'h198, 8'hFD);
    wr(9'h1E0, 8'hFD);
    rd(9'h1E1, 8'h1C);
    rd(9'h198, 8'h01);
    rd(9'h1E0, 8'h05);
    `CHK({pd_input_section_out, divider_powered_down_out, duty_correction_enable_out}, 3'h1)
    upd;
    rd(9'h232, 8'h00);
    `CHK({pd_input_section_out, divider_powered_down_out, duty_correction_enable_out}, 3'h6)
    for (int i = 2; i < 5; i++)
    begin
      wr(9'h1E1, 8'h01 << i);
      upd;
      `CHK({pd_input_section_out, pd_vco_iface_out, pd_sources_out}, 3'(1 << (i - 2)))
    end
    wr(9'h197, 8'h00);
    wr(9'h198, 8'h00);
    wr(9'h1E1, 8'h01);
    wr(9'h196, 8'h21);
    rd(9'h196, 8'h21);
    upd;
    meas(2, 3);
    wr(9'h1E1, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      wr(9'h1E0, 8'(k));
      upd;
      meas(2 * (k + 2), 3 * (k + 2));
    end
    wr(9'h1E1, 8'h01);
    wr(9'h197, 8'h80);
    upd;
    meas(1, 1);
    wr(9'h197, 8'h60);
    upd;
    repeat (20) step;
    `CHK(obs, 1'b1)
    repeat (3) step;
    `CHK(obs, 1'b1)
    wr(9'h197, 8'h20);
    upd;
    meas(2, 3);
    sync_n_in <= 1'b0;
    wr(9'h197, 8'h10);
    upd;
    repeat (10) step;
    `CHK(obs, 1'b1)
    repeat (3) step;
    `CHK(obs, 1'b1)
    wr(9'h197, 8'h40);
    upd;
    meas(2, 3);
    sync_n_in <= 1'b1;
    wr(9'h198, 8'h02);
    wr(9'h1E1, 8'h00);
    upd;
    meas(1, 1);
    wr(9'h1E1, 8'h01);
    upd;
    meas(2, 3);
    ext_clk_tick_in <= 1'b0;
    vco_tick_in <= 1'b1;
    wr(9'h1E1, 8'h02);
    upd;
    meas(1, 1);
    give_verdict;
  end
endmodule
